// [gain_integ_pkg.sv]
// constants shared by the measurement, gain and integration core
// assumes a 25 MHz system clock and a byte-wide register port
`default_nettype none
package gain_integ_pkg;
   // =========================================================
   // register offsets
   localparam logic [7:0] GAIN_CFG_ADDR  = 8'h00;
   localparam logic [7:0] INTEG_CFG_ADDR = 8'h01;
   localparam logic [7:0] CTRL_ADDR      = 8'h02;
   localparam logic [7:0] BUS_HI_ADDR    = 8'h10;
   localparam logic [7:0] BUS_LO_ADDR    = 8'h11;
   localparam logic [7:0] SENSE_HI_ADDR  = 8'h12;
   localparam logic [7:0] SENSE_LO_ADDR  = 8'h13;
   localparam logic [7:0] OVF_ADDR       = 8'h1c;
   localparam logic [7:0] POWER_HI_ADDR  = 8'h1d;
   localparam logic [7:0] POWER_LO_ADDR  = 8'h1e;
   // =========================================================
   // field positions
   localparam int IGAIN_LSB      = 0;
   localparam int VGAIN_LSB      = 3;
   localparam int SENSE_RES_BIT  = 6;
   localparam int BUS_RES_BIT    = 7;
   localparam int MODE_LSB       = 0;
   localparam int BUS_FILT_BIT   = 2;
   localparam int SENSE_FILT_BIT = 3;
   localparam int SAMPLE_COUNT_FIELD_LSB       = 4;
   localparam int INTEG_EN_BIT   = 0;
   localparam int RECALC_BIT     = 1;
   localparam int POWER_OVF_BIT  = 0;
   localparam int BUS_OVF_BIT    = 1;
   localparam int SENSE_OVF_BIT  = 2;
   // =========================================================
   // reset values and codes
   localparam logic [7:0] GAIN_CFG_RST  = 8'h00;
   localparam logic [7:0] INTEG_CFG_RST = 8'h00;
   localparam logic [1:0] MODE_PIN_POWER = 2'h0;
   localparam logic [1:0] MODE_SENSE     = 2'h1;
   localparam logic [1:0] MODE_BUS       = 2'h2;
   localparam logic [1:0] MODE_POWER     = 2'h3;
   localparam logic       CHAN_SENSE     = 1'b0;
   localparam logic       CHAN_BUS       = 1'b1;
   localparam logic [3:0] SAMPLE_COUNT_FIELD_MAX_CODE  = 4'hb;
   localparam logic [2:0] VGAIN_MAX_CODE = 3'h5;
   // =========================================================
   // widths and saturation
   localparam int ADC_W       = 14;
   localparam int RES11_DROP  = 3;
   localparam int RESULT_W    = 10;
   localparam int SENSE_ACC_W = 25;
   localparam int POWER_ACC_W = 39;
   localparam logic [RESULT_W-1:0] RESULT_MAX = 10'h3ff;
   localparam logic [7:0] SAT_HI_BYTE = 8'hff;
   localparam logic [7:0] SAT_LO_BYTE = 8'hc0;
   // =========================================================
   // timing: conversion and end-of-period calculation
   localparam int CLK_PERIOD_NS = 40;
   localparam int CONV11_NS     = 245000;
   localparam int CONV14_NS     = 475000;
   localparam int CALC_NS       = 265000;
   localparam int CONV11_CYCLES =
      (CONV11_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV14_CYCLES =
      (CONV14_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CALC_CYCLES   =
      (CALC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// [gain_scale.sv]
// applies a power-of-two digital gain to an averaged value
// assumes the shift never exceeds 15
`default_nettype none
module gain_scale
   import gain_integ_pkg::*;
#(
   parameter int W = 14
) (
   input  wire logic [W-1:0]        avg_i,
   input  wire logic [4:0]          shift_i,
   output logic      [RESULT_W-1:0] result_o,
   output logic                     ovf_o
);
   localparam int EW = W + 16;

   logic [EW-1:0] ext;

   assign ext      = {16'h0000, avg_i} << shift_i;
   // any bit pushed above the value's own width is an overflow
   assign ovf_o    = |ext[EW-1:W];
   assign result_o = ext[W-1:W-RESULT_W];
endmodule
`default_nettype wire

// [measure_gain_integ.sv]
// measurement scheduler, accumulators, digital gain and result registers
// assumes a serial slave delivers byte reads and writes on reg_* ports
// and the adc presents its finished sample on adc_sample_i
//
// How it works
// - sense and bus channels each pick 11- or 14-bit conversions.
// - filtering stretches a conversion to one and a half times.
// - separate filter enables for sense and bus channels.
// - power mode converts bus then sense for every power sample.
// - sense-only or bus-only modes convert just that channel.
// - samples per period come from the four-bit sample-count field.
// - power period grows with sample count and resolution.
// - current gain is 1x doubling to 128x by three-bit code.
// - voltage gain doubles to 32x; codes above five stay 32x.
// - both gains and both resolution bits share the gain register.
// - current-gain overflow sets sense flag, power flag if power overflowed.
// - current-gain overflow saturates sense result to ff, c0.
// - power overflow saturates power result to ff, c0.
// - voltage-gain overflow sets bus flag, power flag if power overflowed.
// - voltage-gain overflow saturates bus result to ff, c0.
// - raw accumulators are never altered by gain.
// - recalculate bit reworks results from stored sums with new gain.
// - sample code 0 is one sample, doubling to 2048, capped.
`default_nettype none
module measure_gain_integ
   import gain_integ_pkg::*;
#(
   parameter logic [19:0] CONV11_CYC = 20'(CONV11_CYCLES),
   parameter logic [19:0] CONV14_CYC = 20'(CONV14_CYCLES),
   parameter logic [19:0] CALC_CYC   = 20'(CALC_CYCLES)
) (
   input  wire logic             sys_clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             reg_wr_i,
   input  wire logic             reg_rd_i,
   input  wire logic [7:0]       reg_addr_i,
   input  wire logic [7:0]       reg_wdata_i,
   output logic      [7:0]       reg_rdata_o,
   input  wire logic [ADC_W-1:0] adc_sample_i,
   output logic                  conv_start_o,
   output logic                  conv_bus_o,
   output logic                  conv_res14_o,
   output logic                  conv_filter_o,
   output logic                  result_update_o,
   output logic                  integrating_o
);
   typedef enum logic [1:0] {ST_READ, ST_LAUNCH, ST_CONVERT, ST_CALC}
      state_type;

   state_type              state_q;
   logic [7:0]             gain_cfg_q;
   logic [7:0]             integ_cfg_q;
   logic                   integ_en_q;
   logic                   recalc_q;
   logic [1:0]             run_mode_q;
   logic [1:0]             run_res_q;
   logic [1:0]             run_filt_q;
   logic [3:0]             run_shift_q;
   logic                   chan_q;
   logic [19:0]            timer_q;
   logic [11:0]            samp_cnt_q;
   logic [ADC_W-1:0]       last_bus_q;
   logic [SENSE_ACC_W-1:0] sense_accumulator_q;
   logic [SENSE_ACC_W-1:0] bus_accumulator_q;
   logic [POWER_ACC_W-1:0] power_accumulator_q;
   logic [SENSE_ACC_W-1:0] sense_total_q;
   logic [SENSE_ACC_W-1:0] bus_total_q;
   logic [POWER_ACC_W-1:0] power_total_q;
   logic [3:0]             tot_shift_q;
   logic [1:0]             tot_mode_q;
   logic [RESULT_W-1:0]    sense_res_q;
   logic [RESULT_W-1:0]    bus_res_q;
   logic [RESULT_W-1:0]    power_res_q;
   logic [2:0]             ovf_q;

   logic                   run_power;
   logic                   first_chan;
   logic                   conv_done;
   logic                   pair_half;
   logic                   period_end;
   logic                   calc_go;
   logic [ADC_W-1:0]       sample;
   logic [2:0]             igain;
   logic [2:0]             vgain;
   logic [3:0]             sample_count_field_code;
   logic [13:0]            sense_avg;
   logic [13:0]            bus_avg;
   logic [27:0]            power_avg;
   logic [RESULT_W-1:0]    sense_gained;
   logic [RESULT_W-1:0]    bus_gained;
   logic [RESULT_W-1:0]    average_current_result;
   logic                   i_ovf;
   logic                   v_ovf;
   logic                   p_ovf;
   logic                   calc_power;
   logic                   sense_flag;
   logic                   bus_flag;

   function automatic logic [19:0] conv_len(input logic res14,
                                            input logic filt);
      logic [19:0] base;
      base = res14 ? CONV14_CYC : CONV11_CYC;
      return filt ? base + (base >> 1) : base;
   endfunction

   // =========================================================
   // host-visible settings
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gain_cfg_q  <= GAIN_CFG_RST;
         integ_cfg_q <= INTEG_CFG_RST;
         integ_en_q  <= 1'b0;
      end else if (reg_wr_i) begin
         unique case (reg_addr_i)
            GAIN_CFG_ADDR:  gain_cfg_q  <= reg_wdata_i;
            INTEG_CFG_ADDR: integ_cfg_q <= reg_wdata_i;
            CTRL_ADDR:      integ_en_q  <= reg_wdata_i[INTEG_EN_BIT];
            default: ;
         endcase
      end
   end

   // recalculate is a strobe; the bit itself never stores
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         recalc_q <= 1'b0;
      end else begin
         recalc_q <= reg_wr_i && reg_addr_i == CTRL_ADDR &&
                     reg_wdata_i[RECALC_BIT];
      end
   end

   // =========================================================
   // scheduling
   assign sample_count_field_code  = integ_cfg_q[SAMPLE_COUNT_FIELD_LSB +: 4];
   assign run_power  = run_mode_q == MODE_POWER ||
                       run_mode_q == MODE_PIN_POWER;
   assign first_chan = (run_mode_q == MODE_SENSE) ? CHAN_SENSE
                                                  : CHAN_BUS;
   assign conv_done  = state_q == ST_CONVERT && timer_q == 20'h00000;
   assign pair_half  = run_power && chan_q == CHAN_BUS;
   assign period_end = conv_done && !pair_half &&
                       samp_cnt_q + 12'h001 == 12'h001 << run_shift_q;
   assign calc_go    = (state_q == ST_CALC && timer_q == 20'h00000) ||
                       recalc_q;

   // mode, resolution, filter and sample-count settings are frozen for a whole period; edits apply to the next
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_mode_q  <= MODE_PIN_POWER;
         run_res_q   <= 2'b00;
         run_filt_q  <= 2'b00;
         run_shift_q <= 4'h0;
      end else if (state_q == ST_READ && integ_en_q) begin
         run_mode_q  <= integ_cfg_q[MODE_LSB +: 2];
         run_res_q   <= {gain_cfg_q[BUS_RES_BIT],
                         gain_cfg_q[SENSE_RES_BIT]};
         run_filt_q  <= {integ_cfg_q[BUS_FILT_BIT],
                         integ_cfg_q[SENSE_FILT_BIT]};
         run_shift_q <= (sample_count_field_code > SAMPLE_COUNT_FIELD_MAX_CODE) ? SAMPLE_COUNT_FIELD_MAX_CODE
                                                    : sample_count_field_code;
      end
   end

   // period length = read cycle + samples x (conversion lengths + one launch cycle each) + calculation
   // pin-controlled power runs here as free-run power
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q    <= ST_READ;
         chan_q     <= CHAN_BUS;
         timer_q    <= 20'h00000;
         samp_cnt_q <= 12'h000;
      end else begin
         unique case (state_q)
            ST_READ: begin
               samp_cnt_q <= 12'h000;
               if (integ_en_q) begin
                  state_q <= ST_LAUNCH;
                  chan_q  <= (integ_cfg_q[MODE_LSB +: 2] == MODE_SENSE)
                             ? CHAN_SENSE : CHAN_BUS;
               end
            end
            ST_LAUNCH: begin
               if (!integ_en_q) begin
                  state_q <= ST_READ;
               end else begin
                  state_q <= ST_CONVERT;
                  timer_q <= conv_len(run_res_q[chan_q],
                                      run_filt_q[chan_q]) - 20'h00001;
               end
            end
            ST_CONVERT: begin
               if (!integ_en_q) begin
                  state_q <= ST_READ; // partial period is dropped
               end else if (timer_q != 20'h00000) begin
                  timer_q <= timer_q - 20'h00001;
               end else if (pair_half) begin
                  chan_q  <= CHAN_SENSE;
                  state_q <= ST_LAUNCH;
               end else begin
                  samp_cnt_q <= samp_cnt_q + 12'h001;
                  chan_q     <= first_chan;
                  if (period_end) begin
                     state_q <= ST_CALC;
                     timer_q <= CALC_CYC - 20'h00001;
                  end else begin
                     state_q <= ST_LAUNCH;
                  end
               end
            end
            ST_CALC: begin
               if (timer_q != 20'h00000) begin
                  timer_q <= timer_q - 20'h00001;
               end else begin
                  state_q <= ST_READ;
               end
            end
         endcase
      end
   end

   // =========================================================
   // accumulation
   // 11-bit conversions keep the 14-bit scale with low bits cleared
   assign sample = run_res_q[chan_q] ? adc_sample_i
      : {adc_sample_i[ADC_W-1:RES11_DROP], 3'h0};

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sense_accumulator_q <= '0;
         bus_accumulator_q   <= '0;
         power_accumulator_q <= '0;
         last_bus_q          <= '0;
      end else if (state_q == ST_READ) begin
         sense_accumulator_q <= '0;
         bus_accumulator_q   <= '0;
         power_accumulator_q <= '0;
      end else if (conv_done) begin
         if (chan_q == CHAN_BUS) begin
            bus_accumulator_q <= bus_accumulator_q + SENSE_ACC_W'(sample);
            last_bus_q        <= sample;
         end else begin
            sense_accumulator_q <= sense_accumulator_q +
                                   SENSE_ACC_W'(sample);
            if (run_power) begin
               power_accumulator_q <= power_accumulator_q +
                  POWER_ACC_W'(last_bus_q) * POWER_ACC_W'(sample);
            end
         end
      end
   end

   // finished sums are kept apart so gain never touches them
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sense_total_q <= '0;
         bus_total_q   <= '0;
         power_total_q <= '0;
         tot_shift_q   <= 4'h0;
         tot_mode_q    <= MODE_PIN_POWER;
      end else if (period_end && integ_en_q) begin
         sense_total_q <= sense_accumulator_q + SENSE_ACC_W'(
                          (chan_q == CHAN_SENSE) ? sample : 14'h0000);
         bus_total_q   <= bus_accumulator_q + SENSE_ACC_W'(
                          (chan_q == CHAN_BUS) ? sample : 14'h0000);
         power_total_q <= power_accumulator_q + (run_power ?
                          POWER_ACC_W'(last_bus_q) *
                          POWER_ACC_W'(sample) : '0);
         tot_shift_q   <= run_shift_q;
         tot_mode_q    <= run_mode_q;
      end
   end

   // =========================================================
   // averaging and digital gain
   assign sense_avg = 14'(sense_total_q >> tot_shift_q);
   assign bus_avg   = 14'(bus_total_q >> tot_shift_q);
   assign power_avg = 28'(power_total_q >> tot_shift_q);
   assign igain     = gain_cfg_q[IGAIN_LSB +: 3];
   assign vgain     = (gain_cfg_q[VGAIN_LSB +: 3] > VGAIN_MAX_CODE)
                      ? VGAIN_MAX_CODE : gain_cfg_q[VGAIN_LSB +: 3];

   gain_scale #(.W(14)) u_sense (
      .avg_i    (sense_avg),
      .shift_i  ({2'b00, igain}),
      .result_o (sense_gained),
      .ovf_o    (i_ovf)
   );

   gain_scale #(.W(14)) u_bus (
      .avg_i    (bus_avg),
      .shift_i  ({2'b00, vgain}),
      .result_o (bus_gained),
      .ovf_o    (v_ovf)
   );

   gain_scale #(.W(28)) u_power (
      .avg_i    (power_avg),
      .shift_i  (5'({2'b00, igain}) + 5'({2'b00, vgain})),
      .result_o (average_current_result),
      .ovf_o    (p_ovf)
   );

   assign calc_power = tot_mode_q == MODE_POWER ||
                       tot_mode_q == MODE_PIN_POWER;
   assign sense_flag = tot_mode_q != MODE_BUS &&
      (i_ovf || (calc_power && p_ovf && igain != 3'h0));
   assign bus_flag   = tot_mode_q != MODE_SENSE &&
      (v_ovf || (calc_power && p_ovf && vgain != 3'h0));

   // flags describe the most recent calculation or recalculation
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sense_res_q <= '0;
         bus_res_q   <= '0;
         power_res_q <= '0;
         ovf_q       <= 3'h0;
      end else if (calc_go) begin
         ovf_q[SENSE_OVF_BIT] <= sense_flag;
         ovf_q[BUS_OVF_BIT]   <= bus_flag;
         ovf_q[POWER_OVF_BIT] <= calc_power && p_ovf;
         if (tot_mode_q != MODE_BUS) begin
            sense_res_q <= sense_flag ? RESULT_MAX : sense_gained;
         end
         if (tot_mode_q != MODE_SENSE) begin
            bus_res_q <= bus_flag ? RESULT_MAX : bus_gained;
         end
         if (calc_power) begin
            power_res_q <= p_ovf ? RESULT_MAX
                                 : average_current_result;
         end
      end
   end

   // =========================================================
   // register reads and strobes
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            GAIN_CFG_ADDR:  reg_rdata_o <= gain_cfg_q;
            INTEG_CFG_ADDR: reg_rdata_o <= integ_cfg_q;
            CTRL_ADDR:      reg_rdata_o <= {7'h00, integ_en_q};
            BUS_HI_ADDR:    reg_rdata_o <= bus_res_q[9:2];
            BUS_LO_ADDR:    reg_rdata_o <= {bus_res_q[1:0], 6'h00};
            SENSE_HI_ADDR:  reg_rdata_o <= sense_res_q[9:2];
            SENSE_LO_ADDR:  reg_rdata_o <= {sense_res_q[1:0], 6'h00};
            OVF_ADDR:       reg_rdata_o <= {5'h00, ovf_q};
            POWER_HI_ADDR:  reg_rdata_o <= power_res_q[9:2];
            POWER_LO_ADDR:  reg_rdata_o <= {power_res_q[1:0], 6'h00};
            default:        reg_rdata_o <= 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         conv_start_o    <= 1'b0;
         conv_bus_o      <= 1'b0;
         conv_res14_o    <= 1'b0;
         conv_filter_o   <= 1'b0;
         result_update_o <= 1'b0;
         integrating_o   <= 1'b0;
      end else begin
         conv_start_o    <= state_q == ST_LAUNCH && integ_en_q;
         if (state_q == ST_LAUNCH) begin
            conv_bus_o    <= chan_q;
            conv_res14_o  <= run_res_q[chan_q];
            conv_filter_o <= run_filt_q[chan_q];
         end
         result_update_o <= calc_go;
         integrating_o   <= state_q != ST_READ;
      end
   end

   // =========================================================
   // checks
   logic        last_start_bus_q;
   logic [19:0] conv_cyc_q;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         last_start_bus_q <= 1'b0;
         conv_cyc_q       <= 20'h00000;
      end else begin
         if (conv_start_o) begin
            last_start_bus_q <= conv_bus_o;
         end
         conv_cyc_q <= conv_start_o ? 20'h00002 : conv_cyc_q + 20'h00001;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_sense_saturate: assert property (
      result_update_o && ovf_q[SENSE_OVF_BIT] |->
      sense_res_q[9:2] == SAT_HI_BYTE &&
      {sense_res_q[1:0], 6'h00} == SAT_LO_BYTE)
      else $error("sense result not saturated on overflow");
   a_bus_saturate: assert property (
      result_update_o && ovf_q[BUS_OVF_BIT] |-> bus_res_q == RESULT_MAX)
      else $error("bus result not saturated on overflow");
   a_power_saturate: assert property (
      result_update_o && ovf_q[POWER_OVF_BIT] |->
      power_res_q == RESULT_MAX &&
      (ovf_q[SENSE_OVF_BIT] || ovf_q[BUS_OVF_BIT]))
      else $error("power overflow without saturation or gain flag");
   a_power_pair_order: assert property (
      conv_start_o && run_power && !conv_bus_o |-> last_start_bus_q)
      else $error("sense conversion not preceded by bus conversion");
   a_sense_only: assert property (
      conv_start_o && run_mode_q == MODE_SENSE |-> !conv_bus_o)
      else $error("bus converted in sense-only mode");
   a_bus_only: assert property (
      conv_start_o && run_mode_q == MODE_BUS |-> conv_bus_o)
      else $error("sense converted in bus-only mode");
   // conv_cyc_q reads k in the k-th cycle of a conversion, for every k from 2 up
   a_conv_length: assert property (
      conv_done && integ_en_q |->
      conv_cyc_q == conv_len(conv_res14_o, conv_filter_o))
      else $error("conversion length wrong");
   a_sample_total: assert property (
      state_q == ST_CONVERT && period_end && integ_en_q |=>
      state_q == ST_CALC && samp_cnt_q == 12'h001 << run_shift_q)
      else $error("period ended at wrong sample count");
   a_recalc_update: assert property (
      recalc_q |=> result_update_o &&
      $stable(power_total_q) && $stable(sense_total_q))
      else $error("recalculation did not update results");

   c_power_overflow: cover property (result_update_o &&
      ovf_q[POWER_OVF_BIT]);
   c_power_period: cover property (state_q == ST_CALC && run_power &&
      run_shift_q == 4'h2);
   c_recalc: cover property (recalc_q ##1 result_update_o);
   c_filtered_conv: cover property (conv_start_o && conv_filter_o);
endmodule
`default_nettype wire

// [adc_far_model.sv]
// adc stand-in that answers each conversion of the measurement core
// assumes the channel select stays put for a whole conversion
`default_nettype none
module adc_far_model
   import gain_integ_pkg::*;
(
   input  wire logic             conv_bus_i,
   input  wire logic [ADC_W-1:0] bus_val_i,
   input  wire logic [ADC_W-1:0] sense_val_i,
   output logic      [ADC_W-1:0] sample_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // =========================================
   // sample of the channel now being converted
   assign sample_o = conv_bus_i ? bus_val_i : sense_val_i;
endmodule
`default_nettype wire

// [measure_gain_integ_tb.sv]
// self-checking bench for the measurement, gain and integration core
// assumes the shortened conversion counts 4, 8 and 3 set below
`default_nettype none
module measure_gain_integ_tb
   import gain_integ_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic             sys_clk_i = 1'b0, rst_n_i = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [7:0]       addr = 8'h00, wdata = 8'h00, rdata;
   logic [ADC_W-1:0] adc, bv = 14'h0000, sv = 14'h0000;
   logic             start, cbus, c14, cflt, upd, integ;
   int               bad_count = 0, comparisons = 0, nst = 0, nbus = 0;
   int               cyc = 0, st_q[$];
   longint           bx, sx;
   logic [31:0]      seed = 32'h1;
   always #20 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) begin
      cyc++;
      if (start === 1'b1) begin
         nst++;
         nbus += cbus;
         st_q.push_back({cyc[28:0], cbus, c14, cflt});
      end
   end
   measure_gain_integ #(.CONV11_CYC(20'h4), .CONV14_CYC(20'h8),
      .CALC_CYC(20'h3)) measure_gain_integ_i (.sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata), .adc_sample_i(adc),
      .conv_start_o(start), .conv_bus_o(cbus), .conv_res14_o(c14),
      .conv_filter_o(cflt), .result_update_o(upd), .integrating_o(integ));
   adc_far_model adc_far_model_i (.conv_bus_i(cbus), .bus_val_i(bv),
      .sense_val_i(sv), .sample_o(adc));
   // =========================================
   // helpers and model
   function automatic logic [31:0] xs(logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   // bit 10 flags overflow; 3ff encodes the ff/c0 saturation pair
   function automatic logic [10:0] sc(longint v, int s, int w);
      longint t;
      t = v << s;
      return (t >> w) != 0 ? 11'h7ff : {1'b0, 10'(t >> (w - 10))};
   endfunction
   task automatic chk(string n, int e, logic [15:0] g);
      comparisons++;
      if (g !== 16'(e)) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr_reg(logic [7:0] a, logic [7:0] d);
      @(posedge sys_clk_i);
      #1 addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge sys_clk_i);
      #1 wr = 1'b0;
   endtask
   task automatic rd_reg(logic [7:0] a, logic [7:0] e, string n);
      @(posedge sys_clk_i);
      #1 addr = a;
      rd = 1'b1;
      @(posedge sys_clk_i);
      #1 rd = 1'b0;
      chk(n, e, rdata);
   endtask
   task automatic wait_upd();
      int i;
      i = 0;
      do begin
         @(posedge sys_clk_i);
         #1 i++;
      end while (upd !== 1'b1 && i < 20000);
      if (i >= 20000) chk("update", 1, 16'h0000);
   endtask
   task automatic chk_all(int gi, int gv);
      logic [10:0] rs, rb, rp;
      logic [7:0]  f;
      int          g;
      g = gv > 5 ? 5 : gv;
      rb = sc(bx, g, 14);
      rs = sc(sx, gi, 14);
      rp = sc(bx * sx, gi + g, 28);
      f = 8'h00;
      f[2] = rs[10] | (rp[10] && gi != 0);
      f[1] = rb[10] | (rp[10] && g != 0);
      f[0] = rp[10];
      // a raised gain flag saturates its whole result pair
      if (f[2]) rs = 11'h7ff;
      if (f[1]) rb = 11'h7ff;
      rd_reg(BUS_HI_ADDR, rb[9:2], "bus_hi");
      rd_reg(BUS_LO_ADDR, {rb[1:0], 6'h00}, "bus_lo");
      rd_reg(SENSE_HI_ADDR, rs[9:2], "sense_hi");
      rd_reg(SENSE_LO_ADDR, {rs[1:0], 6'h00}, "sense_lo");
      rd_reg(POWER_HI_ADDR, rp[9:2], "power_hi");
      rd_reg(POWER_LO_ADDR, {rp[1:0], 6'h00}, "power_lo");
      rd_reg(OVF_ADDR, f, "flags");
   endtask
   task automatic wrap_up();
      $display("counts: %0d compared, %0d bad", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // =========================================
   // tests
   initial begin
      repeat (5) @(posedge sys_clk_i);
      #1 rst_n_i = 1'b1;
      rd_reg(GAIN_CFG_ADDR, GAIN_CFG_RST, "gain_cfg");
      rd_reg(8'h05, 8'h00, "unmapped");
      wr_reg(BUS_HI_ADDR, 8'h5a);
      rd_reg(BUS_HI_ADDR, 8'h00, "bus_hi_ro");
      $display("test registers done");
      seed = xs(seed);
      bv = seed[13:0];
      seed = xs(seed);
      sv = seed[13:0];
      bx = bv;
      sx = {sv[13:3], 3'h0};
      wr_reg(GAIN_CFG_ADDR, 8'h80);
      wr_reg(INTEG_CFG_ADDR, 8'h07);
      wr_reg(CTRL_ADDR, 8'h01);
      wait_upd();
      chk("integrating", 1, 16'(integ));
      wr_reg(CTRL_ADDR, 8'h00);
      chk("bus_conv", 7, 16'(st_q[0] & 7));
      chk("sense_conv", 0, 16'(st_q[1] & 7));
      chk("spacing", 13, 16'((st_q[1] >> 3) - (st_q[0] >> 3)));
      $display("test power done");
      // recalculation avoids a full period per gain pair
      for (int gi = 0; gi < 8; gi++) begin
         for (int gv = 0; gv < 8; gv++) begin
            wr_reg(GAIN_CFG_ADDR, 8'(128 + gv * 8 + gi));
            wr_reg(CTRL_ADDR, 8'h02);
            repeat (3) @(posedge sys_clk_i);
            chk_all(gi, gv);
         end
      end
      $display("test gains done");
      wr_reg(GAIN_CFG_ADDR, 8'h00);
      wr_reg(INTEG_CFG_ADDR, 8'hf2);
      nst = 0;
      nbus = 0;
      wr_reg(CTRL_ADDR, 8'h01);
      wait_upd();
      chk("samples", 2048, 16'(nst));
      chk("bus_only", 2048, 16'(nbus));
      wr_reg(CTRL_ADDR, 8'h00);
      bx = {bv[13:3], 3'h0};
      rd_reg(BUS_HI_ADDR, 8'(bx >> 6), "bus_hi_avg");
      chk("idle", 0, 16'(integ));
      $display("test bus only done");
      wr_reg(GAIN_CFG_ADDR, 8'h40);
      wr_reg(INTEG_CFG_ADDR, 8'h19);
      nst = 0;
      nbus = 0;
      wr_reg(CTRL_ADDR, 8'h01);
      wait_upd();
      chk("sense_samples", 2, 16'(nst));
      chk("sense_only", 0, 16'(nbus));
      wr_reg(CTRL_ADDR, 8'h00);
      rd_reg(SENSE_HI_ADDR, sv[13:6], "sense_hi_avg");
      $display("test sense only done");
      wrap_up();
   end
   initial begin
      repeat (40000) @(posedge sys_clk_i);
      chk("watchdog", 1, 16'h0000);
      wrap_up();
   end
endmodule
`default_nettype wire
